/* src/sac_pkg.sv */
// shared constants and state carriers for the serial adc control block
package sac_pkg;

    // result, address and channel geometry
    localparam int RES_BITS        = 8;
    localparam int ADDR_BITS       = 5;
    localparam int NUM_EXT_CH      = 19;
    localparam int NUM_CH          = 20;
    localparam logic [ADDR_BITS-1:0] SELFTEST_CH = 5'h13;

    // framing and timing, in clock periods
    localparam int FRAME_EDGES     = 8;
    localparam int OUT_SHIFTS      = 7;
    localparam int CONV_CYCLES     = 36;
    localparam int SAMPLE_CYCLES   = 20;
    localparam int CS_GUARD_CYCLES = 3;

    localparam int CNT_W           = 6;
    localparam int EDGE_W          = 4;
    localparam int GUARD_W         = 2;

    localparam logic [EDGE_W-1:0]  EDGE_LAST   = 4'h7;
    localparam logic [EDGE_W-1:0]  OUT_LAST    = 4'h7;
    localparam logic [GUARD_W-1:0] GUARD_LOAD  = 2'h3;

    // converter sequence, gray coded along idle -> sample -> trial
    typedef enum logic [1:0] {
        SAC_IDLE   = 2'b00,
        SAC_SAMPLE = 2'b01,
        SAC_TRIAL  = 2'b11
    } sac_conv_st_t;

    // successive approximation state
    typedef struct packed {
        sac_conv_st_t          st;
        logic [CNT_W-1:0]      cnt;
        logic [RES_BITS-1:0]   mask;
        logic [RES_BITS-1:0]   code;
        logic [RES_BITS-1:0]   result;
        logic                  done;
        logic                  busy;
        logic                  sampling;
    } sac_sar_t;

    // link side, cleared by chip select going inactive
    typedef struct packed {
        logic [EDGE_W-1:0]     edges;
        logic [ADDR_BITS-1:0]  shift;
    } sac_frame_t;

    // link side, survives between frames
    typedef struct packed {
        logic [ADDR_BITS-1:0]  addr_store;
        logic                  start_tgl;
    } sac_hand_t;

    // system clock side
    typedef struct packed {
        logic                  cs_meta;
        logic                  cs_sync;
        logic                  cs_prev;
        logic                  st_meta;
        logic                  st_sync;
        logic                  st_prev;
        logic                  fl_meta;
        logic                  fl_sync;
        logic                  fl_prev;
        logic                  md_meta;
        logic                  md_sync;
        logic [GUARD_W-1:0]    guard;
        logic [RES_BITS-1:0]   out_sh;
        logic [EDGE_W-1:0]     out_cnt;
        logic                  data_out;
        logic                  data_oe;
        logic [ADDR_BITS-1:0]  ch_sel;
        logic                  sample_hold;
    } sac_sys_t;

endpackage

/* src/sac_sar.sv */
// successive approximation sequencer, one conversion per start pulse
`timescale 1ns/1ps
`default_nettype none
module sac_sar
    import sac_pkg::*;
#(
    parameter int WIDTH   = RES_BITS,
    parameter int CONV    = CONV_CYCLES,
    parameter int SAMPLE  = SAMPLE_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic             cmp_in,
    output logic [WIDTH-1:0]      dac_code,
    output logic [WIDTH-1:0]      result,
    output logic                  done,
    output logic                  busy,
    output logic                  sampling
);
    localparam int TRIAL = (CONV - SAMPLE) / WIDTH;
    localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE - 1);
    localparam logic [CNT_W-1:0] TRIAL_LOAD  = CNT_W'(TRIAL - 1);
    localparam logic [WIDTH-1:0] MSB_MASK    = {1'b1, {(WIDTH-1){1'b0}}};

    // refuse timings that do not split into whole bit trials
    if (WIDTH != RES_BITS || SAMPLE < 1 || TRIAL < 1 || (CONV - SAMPLE) % WIDTH != 0
        || CONV >= (1 << CNT_W)) begin : g_bad
        $error("sac_sar: conversion timing does not fit");
    end

    sac_sar_t s_r;
    sac_sar_t s_nxt;
    logic [WIDTH-1:0] kept;

    // sample phase, then one trial per bit from msb down
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        kept = cmp_in ? s_r.code : (s_r.code & ~s_r.mask);
        case (s_r.st)
            SAC_IDLE: begin
                if (start) begin
                    s_nxt.st       = SAC_SAMPLE;
                    s_nxt.cnt      = SAMPLE_LOAD;
                    s_nxt.code     = '0;
                    s_nxt.busy     = 1'b1;
                    s_nxt.sampling = 1'b1;
                end
            end
            SAC_SAMPLE: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st       = SAC_TRIAL;
                    s_nxt.cnt      = TRIAL_LOAD;
                    s_nxt.mask     = MSB_MASK;
                    s_nxt.code     = MSB_MASK;
                    s_nxt.sampling = 1'b0;
                end else begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
            end
            SAC_TRIAL: begin
                // keep or drop the trial bit
                if (s_r.cnt != '0) begin
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end else if (s_r.mask[0]) begin
                    s_nxt.st     = SAC_IDLE;
                    s_nxt.result = kept;
                    s_nxt.code   = kept;
                    s_nxt.done   = 1'b1;
                    s_nxt.busy   = 1'b0;
                end else begin
                    s_nxt.cnt  = TRIAL_LOAD;
                    s_nxt.mask = s_r.mask >> 1;
                    s_nxt.code = kept | (s_r.mask >> 1);
                end
            end
            default: begin
                s_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dac_code = s_r.code;
    assign result   = s_r.result;
    assign done     = s_r.done;
    assign busy     = s_r.busy;
    assign sampling = s_r.sampling;
endmodule // sac_sar
`default_nettype wire

/* src/sac_serial_adc_ctrl.sv */
// serial control and sequencing top of the 8-bit converter
`timescale 1ns/1ps
`default_nettype none
// Function
// - eighth transfer clock starts 36-cycle conversion
// - conversion uses address store at start
// - msb of old result on select
// - seven lower bits on falling edges
// - ignore transfer clock falls three cycles after select edge
// - twenty-way selector, nineteen inputs plus self-test
// - automatic or host-controlled sample and hold
// - address in while result shifts out
// - four control inputs, one three-state output
// - eight-bit successive approximation result
// - address sampled on transfer clock rising edge
module sac_serial_adc_ctrl
    import sac_pkg::*;
#(
    parameter int RBITS = RES_BITS,
    parameter int ABITS = ADDR_BITS
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             io_clk,
    input  wire logic             cs_n,
    input  wire logic             addr_in,
    input  wire logic             sh_host_mode,
    input  wire logic             cmp_in,
    output logic                  data_out,
    output logic                  data_oe,
    output logic [ABITS-1:0]      ch_sel,
    output logic                  sample_hold,
    output logic [RBITS-1:0]      dac_code,
    output logic                  busy
);
    // refuse geometry the fixed framing cannot carry
    if (RBITS != RES_BITS || ABITS != ADDR_BITS || ABITS >= FRAME_EDGES
        || NUM_CH > (1 << ABITS)) begin : g_bad
        $error("sac_serial_adc_ctrl: unsupported widths");
    end

    sac_frame_t  fr_r;
    sac_frame_t  fr_nxt;
    sac_hand_t   hd_r;
    sac_hand_t   hd_nxt;
    logic        fall_tgl_r;
    sac_sys_t    sy_r;
    sac_sys_t    sy_nxt;

    logic               frame_clr;
    logic               start_evt;
    logic               fall_evt;
    logic               cs_fell;
    logic               cs_rose;
    logic               sar_busy;
    logic               sar_sampling;
    logic [RBITS-1:0]   sar_result;

    // link domain: a frame ends when select goes inactive, clock or not
    assign frame_clr = rst | cs_n;

    // rising transfer clock: count edges, shift address msb first
    always_comb begin
        fr_nxt = fr_r;
        hd_nxt = hd_r;
        if (fr_r.edges != EDGE_LAST + 1'b1) begin
            fr_nxt.edges = fr_r.edges + 1'b1;
        end
        // address shifts in beside the result
        if (fr_r.edges < EDGE_W'(ABITS)) begin
            fr_nxt.shift = {fr_r.shift[ABITS-2:0], addr_in};
        end
        if (fr_r.edges == EDGE_LAST) begin
            hd_nxt.addr_store = fr_r.shift;
            hd_nxt.start_tgl  = ~hd_r.start_tgl;
        end
    end

    always_ff @(posedge io_clk or posedge frame_clr) begin
        if (frame_clr) begin
            fr_r <= '0;
        end else begin
            fr_r <= fr_nxt;
        end
    end

    // address store and start toggle outlive the frame
    always_ff @(posedge io_clk or posedge rst) begin
        if (rst) begin
            hd_r <= '0;
        end else begin
            hd_r <= hd_nxt;
        end
    end

    // falling edges become a toggle so the system side can count them
    always_ff @(negedge io_clk or posedge rst) begin
        if (rst) begin
            fall_tgl_r <= 1'b0;
        end else begin
            fall_tgl_r <= ~fall_tgl_r;
        end
    end

    // system side event decode from synchronised copies only
    assign cs_fell   = ~sy_r.cs_sync & sy_r.cs_prev;
    assign cs_rose   = sy_r.cs_sync & ~sy_r.cs_prev;
    assign fall_evt  = (sy_r.fl_sync ^ sy_r.fl_prev) & ~sy_r.cs_sync & (sy_r.guard == '0);
    // a start during a conversion is dropped
    // no guard here: the start was clocked in before select rose, so a
    // frame closed right after the eighth edge must not lose it
    assign start_evt = (sy_r.st_sync ^ sy_r.st_prev) & ~sar_busy;

    // system clock: synchronisers, output shifter, selector, sample control
    always_comb begin
        sy_nxt = sy_r;
        sy_nxt.cs_meta = cs_n;
        sy_nxt.cs_sync = sy_r.cs_meta;
        sy_nxt.cs_prev = sy_r.cs_sync;
        sy_nxt.st_meta = hd_r.start_tgl;
        sy_nxt.st_sync = sy_r.st_meta;
        sy_nxt.st_prev = sy_r.st_sync;
        sy_nxt.fl_meta = fall_tgl_r;
        sy_nxt.fl_sync = sy_r.fl_meta;
        sy_nxt.fl_prev = sy_r.fl_sync;
        sy_nxt.md_meta = sh_host_mode;
        sy_nxt.md_sync = sy_r.md_meta;

        // noise guard after each select edge
        if (cs_fell || cs_rose) begin
            sy_nxt.guard = GUARD_LOAD;
        end else if (sy_r.guard != '0) begin
            sy_nxt.guard = sy_r.guard - 1'b1;
        end

        if (cs_fell) begin
            sy_nxt.out_sh   = sar_result;
            sy_nxt.out_cnt  = '0;
            sy_nxt.data_out = sar_result[RBITS-1];
            sy_nxt.data_oe  = 1'b1;
        end else if (cs_rose) begin
            sy_nxt.data_oe  = 1'b0;
            sy_nxt.data_out = 1'b0;
        end else if (fall_evt && sy_r.out_cnt != OUT_LAST) begin
            // next lower bit per falling edge
            sy_nxt.out_sh   = {sy_r.out_sh[RBITS-2:0], 1'b0};
            sy_nxt.data_out = sy_r.out_sh[RBITS-2];
            sy_nxt.out_cnt  = sy_r.out_cnt + 1'b1;
        end

        if (start_evt) begin
            if (hd_r.addr_store < ABITS'(NUM_EXT_CH)) begin
                sy_nxt.ch_sel = hd_r.addr_store;
            end else begin
                sy_nxt.ch_sel = SELFTEST_CH;
            end
        end

        // host mode tracks while selected and idle
        if (sy_r.md_sync) begin
            sy_nxt.sample_hold = ~sy_r.cs_sync & ~sar_busy & ~start_evt;
        end else begin
            sy_nxt.sample_hold = sar_sampling | start_evt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sy_r <= '0;
            sy_r.cs_meta <= 1'b1;  // start deselected, no false select edge
            sy_r.cs_sync <= 1'b1;
            sy_r.cs_prev <= 1'b1;
        end else begin
            sy_r <= sy_nxt;
        end
    end

    // conversion runs on the system clock
    sac_sar #(
        .WIDTH  (RBITS),
        .CONV   (CONV_CYCLES),
        .SAMPLE (SAMPLE_CYCLES)
    ) u_sar (
        .clk      (clk),
        .rst      (rst),
        .start    (start_evt),
        .cmp_in   (cmp_in),
        .dac_code (dac_code),
        .result   (sar_result),
        .done     (),
        .busy     (sar_busy),
        .sampling (sar_sampling)
    );

    // three-state output as data plus enable
    assign data_out    = sy_r.data_out;
    assign data_oe     = sy_r.data_oe;
    assign ch_sel      = sy_r.ch_sel;
    assign sample_hold = sy_r.sample_hold;
    assign busy        = sar_busy;
endmodule // sac_serial_adc_ctrl
`default_nettype wire

/* tb/sac_serial_adc_ctrl_properties.sv */
// checker on the serial adc control top ports
`timescale 1ns/1ps
`default_nettype none
module sac_serial_adc_ctrl_properties
    import sac_pkg::*;
#(
    parameter int RBITS = RES_BITS,
    parameter int ABITS = ADDR_BITS
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             cs_n,
    input wire logic             sh_host_mode,
    input wire logic             data_out,
    input wire logic             data_oe,
    input wire logic [ABITS-1:0] ch_sel,
    input wire logic             sample_hold,
    input wire logic [RBITS-1:0] dac_code,
    input wire logic             busy
);
    logic [5:0]       busy_cnt_r;
    logic [RBITS-1:0] last_res_r;
    // conversion length, and the code left standing when it ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt_r <= 6'h00;
            last_res_r <= '0;
        end else begin
            busy_cnt_r <= busy ? busy_cnt_r + 6'h01 : 6'h00;
            if (!busy && busy_cnt_r != 6'h00) last_res_r <= dac_code;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // windows leave slack for the select synchroniser
    conv_length_a: assert property ($fell(busy) |-> busy_cnt_r == 6'h24)
        else $error("conversion length is not 36 cycles");
    sel_at_start_a: assert property (!$rose(busy) |-> $stable(ch_sel))
        else $error("selector moved outside a start");
    msb_first_a: assert property ($fell(cs_n) |-> ##[2:4] (data_oe && data_out == last_res_r[RBITS-1]))
        else $error("old msb not shown after select");
    quiet_guard_a: assert property ($fell(cs_n) |-> !data_oe ##1 !data_oe)
        else $error("answered inside the select guard");
    sel_range_a: assert property (ch_sel <= SELFTEST_CH)
        else $error("selector code out of range");
    auto_hold_a: assert property ($rose(busy) |-> ##25 !sample_hold)
        else $error("not holding during trials");
    host_hold_a: assert property ($rose(busy) && sh_host_mode |=> !sample_hold)
        else $error("host mode not holding at start");
    trial_start_a: assert property ($rose(busy) |-> (dac_code == '0) [*8] ##[12:15] dac_code == 8'h80)
        else $error("first trial code wrong or late");
    out_release_a: assert property (cs_n [*5] |-> !data_oe && !data_out)
        else $error("output driven while deselected");
    // main scenarios reached
    cover property ($rose(busy) && sh_host_mode);
    cover property ($fell(busy) && ch_sel == SELFTEST_CH);
    cover property ($rose(data_oe) && data_out);
endmodule // sac_serial_adc_ctrl_properties
bind sac_serial_adc_ctrl sac_serial_adc_ctrl_properties #(.RBITS(RBITS), .ABITS(ABITS)) chk_u (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sh_host_mode(sh_host_mode), .data_out(data_out),
    .data_oe(data_oe), .ch_sel(ch_sel), .sample_hold(sample_hold), .dac_code(dac_code),
    .busy(busy));
`default_nettype wire

/* tb/sac_host_model.sv */
// host controller stand-in driving the serial control inputs
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
    input  wire logic clk,
    input  wire logic data_out,
    input  wire logic data_oe,
    output logic      io_clk,
    output logic      cs_n,
    output logic      addr_in
);
    initial begin
        io_clk  = 1'b0;
        cs_n    = 1'b1;
        addr_in = 1'b0;
    end

    // one frame: old msb at select, seven bits after falls, address msb first
    task automatic xfer(input logic [4:0] a, input int tail, output logic [7:0] rd,
                        output logic oe);
        @(posedge clk) #1;
        cs_n = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        oe    = data_oe;
        rd[7] = data_out;
        for (int k = 0; k < 8; k++) begin
            // bit set in the low phase
            addr_in = (k < 5) ? a[4-k] : ~addr_in;
            #16 io_clk = 1'b1;
            #16 io_clk = 1'b0;
            addr_in = ~addr_in;
            // low phase stretched so the slow crossing settles before reading
            if (k < 7) begin
                repeat (6) @(posedge clk);
                #1;
                rd[6-k] = data_out;
            end
        end
        // a tail of zero ends the frame right after the eighth fall
        repeat (tail) @(posedge clk);
        #1;
        cs_n = 1'b1;
    endtask
endmodule // sac_host_model
`default_nettype wire

/* tb/sac_serial_adc_ctrl_tb.sv */
// self-checking bench for the serial adc control block
`timescale 1ns/1ps
`default_nettype none
module sac_serial_adc_ctrl_tb;
    import sac_pkg::*;
    logic       clk, rst, io_clk, cs_n, addr_in, sh_host_mode, cmp_in;
    logic       data_out, data_oe, sample_hold, busy, prev_ok;
    logic [4:0] ch_sel;
    logic [7:0] dac_code, vin, prev_res;
    int         miscompares, checked;
    // analog stand-in: level follows the channel, so a wrong channel shows
    assign vin    = {ch_sel, 3'h5};
    assign cmp_in = vin >= dac_code;
    // system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    sac_serial_adc_ctrl dut_u (.clk(clk), .rst(rst), .io_clk(io_clk), .cs_n(cs_n),
        .addr_in(addr_in), .sh_host_mode(sh_host_mode), .cmp_in(cmp_in),
        .data_out(data_out), .data_oe(data_oe), .ch_sel(ch_sel),
        .sample_hold(sample_hold), .dac_code(dac_code), .busy(busy));
    sac_host_model host_u (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .io_clk(io_clk), .cs_n(cs_n), .addr_in(addr_in));
    // compare and count
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // wait out the conversion with select held high
    task automatic settle();
        for (int n = 0; n < 100 && busy !== 1'b0; n++) @(posedge clk) #1;
        if (busy !== 1'b0) miscompares++;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // full frame: read previous result, load a channel, follow the conversion
    task automatic frame(input logic [4:0] a, input logic host, input int tail);
        logic [7:0] rd;
        logic       oe;
        logic [4:0] ech;
        ech = (a > 5'h12) ? SELFTEST_CH : a;
        host_u.xfer(a, tail, rd, oe);
        // the start needs a few cycles to cross after the eighth edge
        repeat (4) @(posedge clk);
        #1;
        chk("drive enable", {7'h00, oe}, 8'h01);
        if (prev_ok) chk("read result", rd, prev_res);
        chk("busy", {7'h00, busy}, 8'h01);
        chk("selector", {3'h0, ch_sel}, {3'h0, ech});
        chk("hold mode", {7'h00, sample_hold}, {7'h00, ~host});
        settle();
        chk("final code", dac_code, {ech, 3'h5});
        chk("released", {7'h00, data_oe}, 8'h00);
        prev_res = {ech, 3'h5};
        prev_ok  = 1'b1;
    endtask
    // nothing driven and nothing converting out of reset
    task automatic t_reset();
        chk("idle enable", {7'h00, data_oe}, 8'h00);
        chk("idle busy", {7'h00, busy}, 8'h00);
    endtask
    // low, mid, last external, self-test and above-range addresses
    task automatic t_channels();
        logic [4:0] tbl [5] = '{5'h00, 5'h05, 5'h12, 5'h13, 5'h1F};
        foreach (tbl[i]) frame(tbl[i], 1'b0, 6);
    endtask
    // host-controlled hold, then automatic again, frames closed at once
    task automatic t_modes();
        for (int m = 1; m >= 0; m--) begin
            sh_host_mode = m[0];
            repeat (4) @(posedge clk);
            #1;
            frame(5'h0A + 5'(m), m[0], 0);
        end
    endtask
    // main sequence
    initial begin
        rst          = 1'b1;
        sh_host_mode = 1'b0;
        miscompares  = 0;
        checked      = 0;
        prev_ok      = 1'b0;
        prev_res     = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_reset();
        t_channels();
        t_modes();
        conclude();
    end
    // watchdog, far beyond the seven frames
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule // sac_serial_adc_ctrl_tb
`default_nettype wire
